// [design/agps_pkg.sv]
// constants, register map and decode helper for the address/gpio pin share
// assumes a 32-bit apb slave with byte addresses and word-aligned registers
package agps_pkg;

    localparam int unsigned DATA_W      = 32;     // apb data width
    localparam int unsigned REG_W       = 16;     // width of the internal register bus
    localparam int unsigned NUM_PADS    = 10;     // shared pads, addr_line6 .. addr_line15
    localparam int unsigned PA_W        = 8;      // port a bits on this group
    localparam int unsigned PA_LSB      = 0;      // port a lowest bit number
    localparam int unsigned PE_W        = 2;      // port e bits on this group
    localparam int unsigned PE_LSB      = 2;      // port e lowest bit number

    // byte offsets of the register map
    localparam logic [7:0]  OFF_CTRL    = 8'h00;  // ext_bus_control_reg
    localparam logic [7:0]  OFF_PA_BASE = 8'h04;  // port a bank base
    localparam logic [7:0]  OFF_PE_BASE = 8'h18;  // port e bank base
    localparam logic [7:0]  OFF_STATUS  = 8'h2C;  // live pin-share status
    localparam logic [7:0]  REL_PER     = 8'h00;  // peripheral enable, 1 = address
    localparam logic [7:0]  REL_DIR     = 8'h04;  // direction, 1 = output
    localparam logic [7:0]  REL_DOUT    = 8'h08;  // output data
    localparam logic [7:0]  REL_PU      = 8'h0C;  // pull-up enable
    localparam logic [7:0]  REL_PIN     = 8'h10;  // pad input level, read only

    // field positions
    localparam int unsigned CTRL_KEEP_BIT = 0;    // bus_drive_keep
    localparam int unsigned ST_ACTIVE_BIT = 0;    // external bus active
    localparam int unsigned ST_CTRLOE_BIT = 1;    // control outputs driven
    localparam int unsigned ST_GPIO_BIT   = 2;    // some pad in gpio mode

    // values after reset
    localparam logic        RST_KEEP    = 1'b0;   // bus released while idle
    localparam logic        RST_PER     = 1'b1;   // address function
    localparam logic        RST_DIR     = 1'b0;   // input
    localparam logic        RST_DOUT    = 1'b0;
    localparam logic        RST_PU      = 1'b1;   // pull-up on

    typedef enum logic [2:0] {
        AGPS_BR_NONE = 3'b000,
        AGPS_BR_PER  = 3'b001,
        AGPS_BR_DIR  = 3'b010,
        AGPS_BR_DOUT = 3'b011,
        AGPS_BR_PU   = 3'b100,
        AGPS_BR_PIN  = 3'b101
    } agps_breg_t;

    // decode a byte address against one bank base
    function automatic agps_breg_t agps_bank_decode(input logic [7:0] addr,
                                                    input logic [7:0] base);
        logic [7:0] rel;
        rel = addr - base;
        if (addr < base)         return AGPS_BR_NONE;
        else if (rel == REL_PER) return AGPS_BR_PER;
        else if (rel == REL_DIR) return AGPS_BR_DIR;
        else if (rel == REL_DOUT) return AGPS_BR_DOUT;
        else if (rel == REL_PU)  return AGPS_BR_PU;
        else if (rel == REL_PIN) return AGPS_BR_PIN;
        else                     return AGPS_BR_NONE;
    endfunction

endpackage

// [design/agps_bank_if.sv]
// carrier between the apb front end and one gpio port bank
// assumes the controller drives one-cycle write strobes in the pclk domain
`timescale 1ns/1ns
interface agps_bank_if #(
    parameter int W = 8
);
    logic                            wr;         // one-cycle write strobe
    agps_pkg::agps_breg_t            sel;        // addressed bank register
    logic [agps_pkg::REG_W-1:0]      wdata;      // write data, port bit numbering
    logic [agps_pkg::REG_W-1:0]      rdata;      // read data, port bit numbering
    logic [W-1:0]                    periph_en;  // 1 = address function
    logic [W-1:0]                    dir;        // 1 = output
    logic [W-1:0]                    dout;       // output level
    logic [W-1:0]                    pu;         // pull-up enable

    modport ctrl (output wr, sel, wdata, input rdata, periph_en, dir, dout, pu);
    modport bank (input wr, sel, wdata, output rdata, periph_en, dir, dout, pu);
endinterface

// [design/agps_port_bank.sv]
// control registers of one gpio port slice: enable, direction, data, pull-up
// assumes the front end decodes the address and gives only aligned strobes
`timescale 1ns/1ns
module agps_port_bank #(
    parameter int unsigned W   = 8,
    parameter int unsigned LSB = 0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    agps_bank_if.bank bus
);
    logic [W-1:0] per_ff;   // peripheral enable
    logic [W-1:0] dir_ff;   // direction per pin
    logic [W-1:0] dout_ff;  // data out
    logic [W-1:0] pu_ff;    // pull-up enable

    // a write loads the whole field at once, each bit its own value, so directions stay independent per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_ff  <= {W{agps_pkg::RST_PER}};
            dir_ff  <= {W{agps_pkg::RST_DIR}};
            dout_ff <= {W{agps_pkg::RST_DOUT}};
            pu_ff   <= {W{agps_pkg::RST_PU}};
        end else if (bus.wr) begin
            if (bus.sel == agps_pkg::AGPS_BR_PER)  per_ff  <= bus.wdata[LSB +: W];
            if (bus.sel == agps_pkg::AGPS_BR_DIR)  dir_ff  <= bus.wdata[LSB +: W];
            if (bus.sel == agps_pkg::AGPS_BR_DOUT) dout_ff <= bus.wdata[LSB +: W];
            if (bus.sel == agps_pkg::AGPS_BR_PU)   pu_ff   <= bus.wdata[LSB +: W];
        end
    end

    // read mux, field sits at the port bit numbers, the rest is zero
    always_comb begin
        bus.rdata = '0;
        case (bus.sel)
            agps_pkg::AGPS_BR_PER:  bus.rdata[LSB +: W] = per_ff;
            agps_pkg::AGPS_BR_DIR:  bus.rdata[LSB +: W] = dir_ff;
            agps_pkg::AGPS_BR_DOUT: bus.rdata[LSB +: W] = dout_ff;
            agps_pkg::AGPS_BR_PU:   bus.rdata[LSB +: W] = pu_ff;
            default:                bus.rdata = '0;
        endcase
    end

    assign bus.periph_en = per_ff;
    assign bus.dir       = dir_ff;
    assign bus.dout      = dout_ff;
    assign bus.pu        = pu_ff;
endmodule

// [design/agps_pin_cell.sv]
// one shared pad: picks address or gpio drive and registers the pad controls
// assumes address and bus-active inputs are synchronous to pclk
`timescale 1ns/1ns
module agps_pin_cell (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic periph_en,    // 1 = address function
    input  wire logic dir,          // gpio direction, 1 = output
    input  wire logic dout,         // gpio output level
    input  wire logic pu,           // pull-up enable
    input  wire logic addr_bit,     // address line from the memory interface
    input  wire logic bus_active,   // external bus cycle in progress
    input  wire logic drive_keep,   // keep address driven while idle
    output logic      pad_out_ff,
    output logic      pad_oe_ff,
    output logic      pad_pu_ff
);
    logic nxt_out;   // pad level
    logic nxt_oe;    // pad enable

    // address mode releases the pad between cycles unless drive_keep is set
    assign nxt_out = periph_en ? addr_bit : dout;
    assign nxt_oe  = periph_en ? (bus_active | drive_keep) : dir;

    // output stays off and pull-up on throughout reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_ff <= 1'b0;
            pad_oe_ff  <= 1'b0;
            pad_pu_ff  <= agps_pkg::RST_PU;
        end else begin
            pad_out_ff <= nxt_out;
            pad_oe_ff  <= nxt_oe;
            pad_pu_ff  <= pu;
        end
    end
endmodule

// [design/agps_top.sv]
// apb front end and pad wiring for the ten shared address/gpio pads
// assumes an apb3 master on pclk, memory interface signals synchronous to pclk,
// and a pad ring that resolves the wire from pad_out, pad_oe and pad_pullup_en
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Function
// - shared pads start in address function
// - idle bus: tri-state or keep, per drive_keep
// - gpio direction selectable per pin
// - pull-up on by default, cleared per bit
// - addr6-7 on port e2-3, 8-15 on a0-7
module agps_top #(
    parameter int unsigned ADDR_W = 12          // apb address width, at least 9
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ADDR_W-1:0]               paddr,
    input  wire logic [agps_pkg::DATA_W-1:0]     pwdata,
    output logic      [agps_pkg::DATA_W-1:0]     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            ext_bus_active,
    input  wire logic [agps_pkg::NUM_PADS-1:0]   ext_addr_hi,
    output logic                                 ext_ctrl_oe,
    input  wire logic [agps_pkg::NUM_PADS-1:0]   pad_in,
    output logic      [agps_pkg::NUM_PADS-1:0]   pad_out,
    output logic      [agps_pkg::NUM_PADS-1:0]   pad_oe,
    output logic      [agps_pkg::NUM_PADS-1:0]   pad_pullup_en
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic                              pready_ff;      // access-phase answer
    logic                              pslverr_ff;     // unmapped access flag
    logic [agps_pkg::DATA_W-1:0]       prdata_ff;      // captured read data
    logic                              keep_ff;        // bus_drive_keep
    logic                              ctrl_oe_ff;     // control output enable
    logic [agps_pkg::NUM_PADS-1:0]     pin_in_ff;      // sampled pad levels
    logic                              nxt_ctrl_oe;    // next control enable

    wire logic                         access;         // apb access phase
    wire logic                         take;           // transfer completes now
    wire logic [7:0]                   addr_lo;        // low address byte
    wire logic                         addr_hi_zero;   // no bits above the map
    wire logic                         hit_ctrl;       // control register
    wire logic                         hit_status;     // status register
    wire logic                         hit_pa;         // port a bank
    wire logic                         hit_pe;         // port e bank
    wire logic                         mapped;         // any register hit
    wire agps_pkg::agps_breg_t         pa_sel;         // port a register
    wire agps_pkg::agps_breg_t         pe_sel;         // port e register
    wire logic                         pa_pin_rd;      // port a level read
    wire logic                         pe_pin_rd;      // port e level read
    wire logic [agps_pkg::REG_W-1:0]   ctrl_word;      // control read value
    wire logic [agps_pkg::REG_W-1:0]   status_word;    // status read value
    wire logic [agps_pkg::REG_W-1:0]   pa_pin_word;    // port a levels
    wire logic [agps_pkg::REG_W-1:0]   pe_pin_word;    // port e levels
    wire logic [agps_pkg::REG_W-1:0]   rd_word;        // selected read value
    wire logic [agps_pkg::NUM_PADS-1:0] pad_periph;    // per-pad address mode
    wire logic [agps_pkg::NUM_PADS-1:0] pad_dir;       // per-pad direction
    wire logic [agps_pkg::NUM_PADS-1:0] pad_dout;      // per-pad gpio level
    wire logic [agps_pkg::NUM_PADS-1:0] pad_pu;        // per-pad pull-up

    agps_bank_if #(.W(agps_pkg::PA_W)) pa_if ();      // port a bank link
    agps_bank_if #(.W(agps_pkg::PE_W)) pe_if ();      // port e bank link

    ////////////////////////////////////////////////////////////////////////////
    // apb address decode

    assign access       = psel & penable;
    // one wait state: the answer flop rises on the edge that ends the first access cycle
    assign take         = access & pready_ff;
    assign addr_lo      = paddr[7:0];
    assign addr_hi_zero = (paddr[ADDR_W-1:8] == '0);

    assign pa_sel = addr_hi_zero ?
                    agps_pkg::agps_bank_decode(addr_lo, agps_pkg::OFF_PA_BASE) :
                    agps_pkg::AGPS_BR_NONE;
    assign pe_sel = addr_hi_zero ?
                    agps_pkg::agps_bank_decode(addr_lo, agps_pkg::OFF_PE_BASE) :
                    agps_pkg::AGPS_BR_NONE;

    // the two bank windows do not overlap, so at most one of these is set
    assign hit_ctrl   = addr_hi_zero & (addr_lo == agps_pkg::OFF_CTRL);
    assign hit_status = addr_hi_zero & (addr_lo == agps_pkg::OFF_STATUS);
    assign hit_pa     = (pa_sel != agps_pkg::AGPS_BR_NONE) &
                        (addr_lo < agps_pkg::OFF_PE_BASE);
    assign hit_pe     = (pe_sel != agps_pkg::AGPS_BR_NONE);
    assign mapped     = hit_ctrl | hit_status | hit_pa | hit_pe;
    assign pa_pin_rd  = hit_pa & (pa_sel == agps_pkg::AGPS_BR_PIN);
    assign pe_pin_rd  = hit_pe & (pe_sel == agps_pkg::AGPS_BR_PIN);

    ////////////////////////////////////////////////////////////////////////////
    // bank strobes
    // writes land only on the completing edge; level and status are read only

    assign pa_if.wr    = take & pwrite & hit_pa;
    assign pa_if.sel   = hit_pa ? pa_sel : agps_pkg::AGPS_BR_NONE;
    assign pa_if.wdata = pwdata[agps_pkg::REG_W-1:0];
    assign pe_if.wr    = take & pwrite & hit_pe;
    assign pe_if.sel   = hit_pe ? pe_sel : agps_pkg::AGPS_BR_NONE;
    assign pe_if.wdata = pwdata[agps_pkg::REG_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // read data selection

    assign ctrl_word   = {{(agps_pkg::REG_W-1){1'b0}}, keep_ff};
    assign status_word = {{(agps_pkg::REG_W-3){1'b0}},
                          ~(&pad_periph), ctrl_oe_ff, ext_bus_active};
    // pad levels shown at their port bit numbers
    assign pa_pin_word = {{(agps_pkg::REG_W-agps_pkg::PA_W){1'b0}},
                          pin_in_ff[agps_pkg::NUM_PADS-1:agps_pkg::PE_W]};
    assign pe_pin_word = {{(agps_pkg::REG_W-agps_pkg::PE_W-agps_pkg::PE_LSB){1'b0}},
                          pin_in_ff[agps_pkg::PE_W-1:0],
                          {agps_pkg::PE_LSB{1'b0}}};

    // unmapped addresses read as zero
    assign rd_word = hit_ctrl   ? ctrl_word   :
                     hit_status ? status_word :
                     pa_pin_rd  ? pa_pin_word :
                     pe_pin_rd  ? pe_pin_word :
                     hit_pa     ? pa_if.rdata :
                     hit_pe     ? pe_if.rdata :
                     '0;

    ////////////////////////////////////////////////////////////////////////////
    // apb answer
    // pready pulses for one cycle; holding it low in the first access cycle
    // keeps every bus output on a flop at the cost of one wait state

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else if (access & !pready_ff) begin
            // first access cycle: answer on the next edge
            pready_ff  <= 1'b1;
            pslverr_ff <= ~mapped;
            prdata_ff  <= (pwrite | ~mapped) ? '0 :
                          {{(agps_pkg::DATA_W-agps_pkg::REG_W){1'b0}}, rd_word};
        end else begin
            // transfer done or bus idle
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ext_bus_control_reg
    // a write to an error-flagged address never reaches here, hit_ctrl is false

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_ff <= agps_pkg::RST_KEEP;
        end else if (take & pwrite & hit_ctrl) begin
            keep_ff <= pwdata[agps_pkg::CTRL_KEEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs of the memory interface follow the same idle rule

    assign nxt_ctrl_oe = ext_bus_active | keep_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_oe_ff <= 1'b0;
            pin_in_ff  <= '0;
        end else begin
            ctrl_oe_ff <= nxt_ctrl_oe;
            pin_in_ff  <= pad_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port banks

    agps_port_bank #(
        .W   (agps_pkg::PA_W),
        .LSB (agps_pkg::PA_LSB)
    ) u_bank_a (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (pa_if)
    );

    agps_port_bank #(
        .W   (agps_pkg::PE_W),
        .LSB (agps_pkg::PE_LSB)
    ) u_bank_e (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (pe_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pad map
    // pads 0..1 carry addr_line6..7 on port_e_pin2..3,
    // pads 2..9 carry addr_line8..15 on port_a_pin0..7, ascending

    assign pad_periph = {pa_if.periph_en, pe_if.periph_en};
    assign pad_dir    = {pa_if.dir, pe_if.dir};
    assign pad_dout   = {pa_if.dout, pe_if.dout};
    assign pad_pu     = {pa_if.pu, pe_if.pu};

    genvar gi;
    generate
        for (gi = 0; gi < agps_pkg::NUM_PADS; gi++) begin : g_pad
            agps_pin_cell u_cell (
                .pclk       (pclk),
                .presetn    (presetn),
                .periph_en  (pad_periph[gi]),
                .dir        (pad_dir[gi]),
                .dout       (pad_dout[gi]),
                .pu         (pad_pu[gi]),
                .addr_bit   (ext_addr_hi[gi]),
                .bus_active (ext_bus_active),
                .drive_keep (keep_ff),
                .pad_out_ff (pad_out[gi]),
                .pad_oe_ff  (pad_oe[gi]),
                .pad_pu_ff  (pad_pullup_en[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // top-level outputs, all from flops

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign ext_ctrl_oe = ctrl_oe_ff;

endmodule

// [verification/agps_mem_model.sv]
// far side of the shared pads: memory parts, outside drivers and pad wires
// assumes the bench raises drv_en where an outside part drives a pad
`timescale 1ns/1ns
module agps_mem_model (
    input  logic       pclk,
    input  logic [9:0] pad_out,
    input  logic [9:0] pad_oe,
    input  logic [9:0] pad_pullup_en,
    input  logic [9:0] drv_en,         // outside part drives the pad
    input  logic [9:0] drv_lvl,        // level that part drives
    output logic [9:0] pad_in
);
    logic [9:0] last_ff = 10'h000;     // wire level one cycle ago
    // memory parts only listen, so they never drive back;
    // a pad nobody drives and nothing pulls shows the inverse of its last level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv_lvl)
                  | (~pad_oe & ~drv_en & (pad_pullup_en | ~last_ff));
    // remember the wire level
    always @(posedge pclk) begin
        last_ff <= pad_in;
    end
endmodule

// [verification/agps_top_asserts.sv]
// concurrent checks on the ports of the pin-share top
// assumes one pclk domain and a bind into every agps_top instance
`timescale 1ns/1ns
module agps_top_asserts #(
    parameter int unsigned ADDR_W = 12
) (
    input logic              pclk,
    input logic              presetn,
    input logic              psel,
    input logic              penable,
    input logic              pwrite,
    input logic [ADDR_W-1:0] paddr,
    input logic [31:0]       pwdata,
    input logic [31:0]       prdata,
    input logic              pready,
    input logic              pslverr,
    input logic              ext_bus_active,
    input logic [9:0]        ext_addr_hi,
    input logic              ext_ctrl_oe,
    input logic [9:0]        pad_in,
    input logic [9:0]        pad_out,
    input logic [9:0]        pad_oe,
    input logic [9:0]        pad_pullup_en
);
    wire wr_done = psel & penable & pready & pwrite;  // a write lands here
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // pads come up as address lines, in line order, pull-ups on
    property p_rst_addr;
        !$past(presetn) |=> pad_out == $past(ext_addr_hi)
            && pad_oe == {10{$past(ext_bus_active)}};
    endproperty
    property p_rst_pu;
        !$past(presetn) |-> &pad_pullup_en;
    endproperty
    // control outputs driven in a bus cycle, dropped only when idle
    property p_act_ctrl;
        $past(presetn) && $past(ext_bus_active) |-> ext_ctrl_oe;
    endproperty
    property p_fell_ctrl;
        $fell(ext_ctrl_oe) |-> !$past(ext_bus_active);
    endproperty
    // drive enables move only after a bus change or a write
    property p_oe_cause;
        $past(presetn, 2) && ($changed(pad_oe) || $changed(ext_ctrl_oe))
            |-> $past(ext_bus_active) != $past(ext_bus_active, 2) || $past(wr_done, 2);
    endproperty
    property p_pu_cause;
        $past(presetn, 2) && $changed(pad_pullup_en) |-> $past(wr_done, 2);
    endproperty
    // one wait state, one-cycle answer, errors read zero
    property p_wait;
        psel && penable && !$past(penable) |-> !pready ##1 pready;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_err;
        pslverr |-> pready && prdata == 32'h00000000;
    endproperty
    a_rst_addr:  assert property (p_rst_addr)  else $error("pads not in address mode");
    a_rst_pu:    assert property (p_rst_pu)    else $error("pull-up off after reset");
    a_act_ctrl:  assert property (p_act_ctrl)  else $error("control not driven");
    a_fell_ctrl: assert property (p_fell_ctrl) else $error("control released early");
    a_oe_cause:  assert property (p_oe_cause)  else $error("drive enable moved alone");
    a_pu_cause:  assert property (p_pu_cause)  else $error("pull-up moved alone");
    a_wait:      assert property (p_wait)      else $error("wrong wait states");
    a_pulse:     assert property (p_pulse)     else $error("ready longer than a cycle");
    a_err:       assert property (p_err)       else $error("error with data");
    c_write: cover property (wr_done);
    c_err:   cover property (pslverr);
    c_keep:  cover property (ext_ctrl_oe && !ext_bus_active);
endmodule
bind agps_top agps_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_bus_active, .ext_addr_hi,
    .ext_ctrl_oe, .pad_in, .pad_out, .pad_oe, .pad_pullup_en);

// [verification/agps_top_tb.sv]
// self-checking bench for the pin-share top against a register-image model
// assumes package, design, checker and pad model compiled first
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module agps_top_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000003C;
    logic pready, pslverr, ext_ctrl_oe, ext_bus_active = 1'b0;
    logic [9:0] ext_addr_hi = 10'h000, pad_in, pad_out, pad_oe, pad_pullup_en;
    logic [9:0] drv_en = 10'h000, drv_lvl = 10'h000;
    logic [9:0] m [4];                 // model: enable, direction, data, pull-up
    logic m_keep;                      // model of bus_drive_keep
    int err_total = 0, check_count = 0, cyc = 0;
    logic [11:0] wtab [9] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                              12'h018, 12'h01C, 12'h020, 12'h024};
    always #5 pclk = ~pclk;
    agps_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_bus_active, .ext_addr_hi, .ext_ctrl_oe, .pad_in, .pad_out,
        .pad_oe, .pad_pullup_en);
    agps_mem_model u_far (.pclk, .pad_out, .pad_oe, .pad_pullup_en, .drv_en, .drv_lvl,
        .pad_in);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // bank register index; port a from 0x04, port e from 0x18
    function automatic int kidx(input logic [11:0] a);
        return ((a < 12'h018) ? a - 12'h004 : a - 12'h018) >> 2;
    endfunction
    function automatic logic [31:0] mdl_rd(input logic [11:0] a);
        if (a == 12'h000) return {31'h0, m_keep};
        if (a < 12'h018) return {24'h0, m[kidx(a)][9:2]};
        return {28'h0, m[kidx(a)][1:0], 2'h0};
    endfunction
    // psel stays up so a next setup may follow at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
        if (a == 12'h000) m_keep = d[0];
        else if (a < 12'h018) m[kidx(a)][9:2] = d[7:0];
        else m[kidx(a)][1:0] = d[3:2];
    endtask
    task automatic rd(input logic [11:0] a);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK({e, r}, {1'b0, mdl_rd(a)})
    endtask
    task automatic set_ext();
        logic [31:0] r;
        r = rnd();
        ext_bus_active <= r[0];
        ext_addr_hi <= r[10:1];
    endtask
    task automatic chk_pads();
        logic [9:0] oe, out;
        oe = (m[0] & {10{ext_bus_active | m_keep}}) | (~m[0] & m[1]);
        out = (m[0] & ext_addr_hi) | (~m[0] & m[2]);
        `CHK(pad_oe, oe)
        `CHK(pad_out, out)
        `CHK(pad_pullup_en, m[3])
        `CHK(ext_ctrl_oe, ext_bus_active | m_keep)
    endtask
    // reset design and model, check the start-up state
    task automatic do_reset();
        psel <= 1'b0;
        presetn <= 1'b0;
        m = '{10'h3FF, 10'h000, 10'h000, 10'h3FF};
        m_keep = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        set_ext();
        repeat (2) @(posedge pclk);
        chk_pads();
        foreach (wtab[i]) rd(wtab[i]);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e;
        logic [11:0] etab [3];
        etab = '{12'h104, 12'h030, 12'h002};
        do_reset();
        // unmapped, aliased and misaligned places are refused with zero data
        foreach (etab[i]) begin
            apb(i == 0, etab[i], 32'h0000FFFF, r, e);
            `CHK({e, r}, {1'b1, 32'h0})
        end
        apb(1'b1, 12'h014, 32'h000000FF, r, e);
        `CHK(e, 1'b0)
        rd(12'h004);
        // random writes and reads, pads against the model
        for (int i = 0; i < 40; i++) begin
            wr(wtab[rnd() % 9], rnd());
            set_ext();
            rd(wtab[rnd() % 9]);
            chk_pads();
        end
        // all pads gpio inputs, outside parts drive them
        for (int i = 0; i < 4; i++) wr(wtab[(i % 2) + 1 + (i / 2) * 4], 32'h0);
        r = rnd();
        drv_en <= 10'h3FF;
        drv_lvl <= r[9:0];
        psel <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h02C, 32'h0, r, e);
        `CHK(e, 1'b0)
        `CHK(r, {30'h1, ext_bus_active | m_keep, ext_bus_active})
        apb(1'b0, 12'h014, 32'h0, r, e);
        `CHK(r, {24'h0, drv_lvl[9:2]})
        apb(1'b0, 12'h028, 32'h0, r, e);
        `CHK(r, {28'h0, drv_lvl[1:0], 2'h0})
        do_reset();
        wr(12'h000, 32'h00000001);
        ext_bus_active <= 1'b0;
        psel <= 1'b0;
        repeat (2) @(posedge pclk);
        chk_pads();
        end_of_test();
    end
endmodule
